// ===== verification/instrument_model.sv
// external instrument model: answers each settled-channel pulse
// assumes relay selection holds until the advance strobe is seen
`default_nettype none
module instrument_model #(
  parameter int DELAY_CYC = 4
) (
  // clock
  input wire logic clk_in,
  // from the sequencer
  input wire logic closed_in,
  input wire logic [7:0] relay_in,
  // to the sequencer
  output logic advance_out,
  output logic [31:0] meas_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    advance_out = 1'b0;
    meas_out = 32'h5A5A_5A5A;
    forever begin
      @(posedge clk_in);
      if (closed_in === 1'b1) begin
        repeat (DELAY_CYC) @(posedge clk_in);
        // reading carries the relay pattern so the bench can tell steps
        meas_out <= 32'h0000_A000 | 32'(relay_in);
        advance_out <= 1'b1;
        repeat (6) @(posedge clk_in);
        advance_out <= 1'b0;
        repeat (2) @(posedge clk_in);
        // released data no longer shows the last value
        meas_out <= ~meas_out;
      end
    end
  end
endmodule // instrument_model
`default_nettype wire

// ===== verification/tb_top.sv
// testbench: apb register tasks drive scans, totalizer and ports
// assumes instrument_model stands on the measurement handshake
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import scan_seq_pkg::*;
`define CHK(nm, ex, got) begin \
  tests_run++; \
  if ((got) !== (ex)) begin \
    err_total++; \
    $display("mismatch %s expected %0h seen %0h", nm, ex, got); \
  end \
end
  logic clk_in;
  logic reset_n_in;
  apb_req_t apb_req;
  apb_rsp_t apb_rsp;
  logic key_in;
  logic ext_trig_in;
  logic advance_in;
  logic tot_in;
  logic [31:0] meas_data_in;
  logic [31:0] dig_in;
  logic [7:0] relay_sel_out;
  logic chan_closed_out;
  logic scanning_out;
  logic [3:0] alarm_out;
  int err_total;
  int tests_run;
  int settle_cnt;
  logic [3:0] ord [2][4] = '{'{4'h1, 4'h3, 4'h5, 4'h8},
                             '{4'h3, 4'h1, 4'h8, 4'h5}};

  scan_sequencer_totalizer dut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .apb_in(apb_req),
    .apb_out(apb_rsp), .key_in(key_in), .ext_trig_in(ext_trig_in),
    .advance_in(advance_in), .meas_data_in(meas_data_in),
    .dig_in(dig_in), .tot_in(tot_in), .relay_sel_out(relay_sel_out),
    .chan_closed_out(chan_closed_out), .alarm_out(alarm_out),
    .scanning_out(scanning_out));

  instrument_model #(.DELAY_CYC(4)) partner (
    .clk_in(clk_in), .closed_in(chan_closed_out),
    .relay_in(relay_sel_out), .advance_out(advance_in),
    .meas_out(meas_data_in));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  function automatic logic [31:0] exp_data(input logic [3:0] c);
    if (c == CODE_DIG0) return 32'h0000_0078;
    return 32'h0000_A000 | (32'h0000_0001 << c);
  endfunction

  task automatic complete_run;
    if (err_total == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic apb_xfer(input logic wr_en, input logic [7:0] addr,
      input logic [31:0] wdat, output logic [31:0] rdat, output logic err);
    int n;
    n = 0;
    @(posedge clk_in);
    apb_req <= '{1'b1, 1'b0, wr_en, addr, wdat};
    @(posedge clk_in);
    apb_req.penable <= 1'b1;
    @(posedge clk_in);
    while (apb_rsp.pready !== 1'b1 && n < 50) begin
      @(posedge clk_in);
      n++;
    end
    if (n == 50) err_total++;
    rdat = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req <= '0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb_xfer(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb_xfer(1'b0, a, 32'h0000_0000, r, e);
  endtask

  task automatic tot_pulses(input int n);
    repeat (n) begin
      @(posedge clk_in);
      tot_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      tot_in <= 1'b0;
      repeat (3) @(posedge clk_in);
    end
  endtask

  task automatic fire(input int s);
    if (s == 2) wr(OFF_CMD, 32'h0000_0004);
    else if (s != 0) begin
      @(posedge clk_in);
      if (s == 1) key_in <= 1'b1;
      else ext_trig_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      key_in <= 1'b0;
      ext_trig_in <= 1'b0;
    end
  endtask

  // relay on-time before the settled pulse, and one relay at a time
  always @(posedge clk_in) begin
    if (relay_sel_out == 8'h00) settle_cnt <= 0;
    else settle_cnt <= settle_cnt + 1;
    if (chan_closed_out === 1'b1)
      `CHK("settle", 1'b1, settle_cnt >= SETTLE_CYC + 2)
    if (reset_n_in) `CHK("one_relay", 1'b1, $onehot0(relay_sel_out))
  end

  initial begin
    #400_000;
    err_total++;
    complete_run();
  end

  initial begin
    logic [31:0] r;
    logic [31:0] stamp;
    logic e;
    logic [3:0] c;
    int n;
    err_total = 0;
    tests_run = 0;
    settle_cnt = 0;
    apb_req = '0;
    key_in = 1'b0;
    ext_trig_in = 1'b0;
    tot_in = 1'b0;
    dig_in = 32'h1234_5678;
    stamp = 32'h0000_0000;
    reset_n_in = 1'b0;
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    rd(OFF_CTRL, r);
    `CHK("ctrl_reset", CTRL_RST, r)
    apb_xfer(1'b0, 8'h44, 32'h0000_0000, r, e);
    `CHK("unmapped", 1'b1, e)
    rd(OFF_DIG, r);
    `CHK("dig_live", 32'h1234_5678, r)
    tot_pulses(5);
    rd(OFF_TOT, r);
    `CHK("tot_rise", 32'h0000_0005, r)
    rd(OFF_TOT, r);
    `CHK("tot_keep", 32'h0000_0005, r)
    wr(OFF_CTRL, 32'h0000_0030);
    tot_pulses(3);
    rd(OFF_TOT, r);
    `CHK("tot_fall", 32'h0000_0008, r)
    rd(OFF_TOT, r);
    `CHK("tot_zero", 32'h0000_0000, r)
    wr(OFF_LIST, 32'h0000_5813);
    wr(OFF_LEN, 32'h0000_0004);
    wr(OFF_CHDLY, 32'h0000_0002);
    wr(OFF_TIMER, 32'h0000_0014);
    wr(OFF_LIMIT, 32'h0000_A010);
    wr(OFF_AL_EN, 32'h0000_0020);
    wr(OFF_AL_SEL, 32'h0000_0800);
    // sources timer, key, soft, ext; odd ones keep stored order
    for (int s = 0; s < 4; s++) begin
      wr(OFF_CTRL, 32'h0000_0100 | 32'(s * 2 + s % 2));
      wr(OFF_CMD, 32'h0000_0001);
      fire(s);
      repeat (2) @(posedge clk_in);
      n = 0;
      while (scanning_out !== 1'b0 && n < 5000) begin
        @(posedge clk_in);
        n++;
      end
      `CHK("scan_end", 1'b0, scanning_out)
      rd(OFF_FILL, r);
      `CHK("fill", 32'h0000_0004, r)
      for (int i = 0; i < 4; i++) begin
        c = ord[s % 2][i];
        wr(OFF_RD_IDX, 32'(i));
        rd(OFF_RD_CHAN, r);
        `CHK("rd_chan", c, r[3:0])
        rd(OFF_RD_DATA, r);
        `CHK("rd_data", exp_data(c), r)
        rd(OFF_RD_STAMP, r);
        if (i > 0) `CHK("stamp_up", 1'b1, r > stamp)
        stamp = r;
      end
      rd(OFF_FILL, r);
      `CHK("fill_kept", 32'h0000_0004, r)
      if (s == 0) begin
        `CHK("alarm_set", 4'b0100, alarm_out)
        wr(OFF_CMD, 32'h0000_0008);
        @(posedge clk_in);
        `CHK("alarm_clr", 4'b0000, alarm_out)
      end
    end
    complete_run();
  end
endmodule // tb_top
`default_nettype wire

// ===== verilog/scan_seq_pkg.sv
// constants, bus carriers and state types of the scan sequencer
// assumes one 25 MHz clock and an apb master that holds each request
// Behaviour
// [RQ1] one channel connected and measured at a time
// [RQ2] only listed channels measured, only while scanning
// [RQ3] default order ascending by channel code
// [RQ4] non-sequential option keeps stored list order
// [RQ5] reading memory holds 500,000 time-stamped readings
// [RQ6] full memory keeps the newest readings
// [RQ7] memory readable anytime, reading leaves it intact
// [RQ8] starting a scan clears old readings
// [RQ9] sweep start: timer, key, software, external, alarm
// [RQ10] programmable delay between successive channels
// [RQ11] closed pulse only after relay settle plus delay
// [RQ12] instrument strobes advance when measurement done
// [RQ13] digital port or totalizer read as step
// [RQ14] 8-bit ports, combinable to 16 or 32 bits
// [RQ15] live digital state readable without scan
// [RQ16] 32-bit totalizer, read manually or scanned
// [RQ17] totalizer counts rising or falling edge
// [RQ18] count wraps to zero after maximum
// [RQ19] read-and-reset option never loses an edge; a bus read drops an edge that falls in its setup cycle
// [RQ20] four alarm outputs, alarm may start sweep
// [RQ21] memory is circular: pointer, wrap flag, fill
// [RQ22] closed and advance are clean synchronised pulses
`default_nettype none
package scan_seq_pkg;
  localparam int CLK_NS = 40;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_DEPTH = 500000;
  localparam int PTR_W = 19;
  localparam logic [PTR_W-1:0] RD_LAST = PTR_W'(RD_DEPTH - 1);
  localparam logic [PTR_W-1:0] RD_FULL = PTR_W'(RD_DEPTH);
  localparam int LIST_LEN = 8;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_LIST = 8'h08;
  localparam logic [7:0] OFF_LEN = 8'h0C;
  localparam logic [7:0] OFF_CHDLY = 8'h10;
  localparam logic [7:0] OFF_TIMER = 8'h14;
  localparam logic [7:0] OFF_LIMIT = 8'h18;
  localparam logic [7:0] OFF_AL_EN = 8'h1C;
  localparam logic [7:0] OFF_AL_SEL = 8'h20;
  localparam logic [7:0] OFF_STAT = 8'h24;
  localparam logic [7:0] OFF_FILL = 8'h28;
  localparam logic [7:0] OFF_RD_IDX = 8'h2C;
  localparam logic [7:0] OFF_RD_DATA = 8'h30;
  localparam logic [7:0] OFF_RD_STAMP = 8'h34;
  localparam logic [7:0] OFF_RD_CHAN = 8'h38;
  localparam logic [7:0] OFF_DIG = 8'h3C;
  localparam logic [7:0] OFF_TOT = 8'h40;
  // field positions and reset values
  localparam int CTRL_NONSEQ = 0;
  localparam int CTRL_SRC_LSB = 1;
  localparam int CTRL_FALL = 4;
  localparam int CTRL_RDRST = 5;
  localparam int CTRL_SWEEP_LSB = 8;
  localparam int CMD_INIT = 0;
  localparam int CMD_ABORT = 1;
  localparam int CMD_SOFT = 2;
  localparam int CMD_ALCLR = 3;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] TIMER_RST = 32'h0000_0000;
  // channel codes: 0..7 relay channels, then digital and totalizer
  localparam logic [3:0] CODE_DIG0 = 4'h8;
  localparam logic [3:0] CODE_DIG16A = 4'hC;
  localparam logic [3:0] CODE_DIG16B = 4'hD;
  localparam logic [3:0] CODE_DIG32 = 4'hE;
  localparam logic [3:0] CODE_TOT = 4'hF;

  typedef enum logic [2:0] {
    TRIG_TIMER, TRIG_KEY, TRIG_SOFT, TRIG_EXT, TRIG_ALARM
  } trig_src_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ARMED, ST_SELECT, ST_SETTLE, ST_WAIT, ST_STORE
  } scan_st_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;
endpackage
`default_nettype wire

// ===== verilog/scan_sequencer_totalizer.sv
// scan sequencer with reading memory, digital ports and totalizer
// assumes apb master on clk_in; pins asynchronous, synchronised here
`default_nettype none
module scan_sequencer_totalizer (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // register bus
  input wire scan_seq_pkg::apb_req_t apb_in,
  output scan_seq_pkg::apb_rsp_t apb_out,
  // pins
  input wire logic key_in,
  input wire logic ext_trig_in,
  input wire logic advance_in,
  input wire logic [31:0] meas_data_in,
  input wire logic [31:0] dig_in,
  input wire logic tot_in,
  // outputs
  output logic [7:0] relay_sel_out,
  output logic chan_closed_out,
  output logic [3:0] alarm_out,
  output logic scanning_out
);
  import scan_seq_pkg::*;

  typedef struct packed {
    scan_st_t st;
    logic [31:0] ctrl, list, chdly, timer, limit, al_sel;
    logic [15:0] al_en;
    logic [3:0] len;
    logic [PTR_W-1:0] wptr, fill, rd_idx;
    logic wrapped;
    logic [31:0] stamp, tmr, dly, tot, meas;
    logic [4:0] pos;
    logic [3:0] code;
    logic [7:0] sweeps_done;
    logic [3:0] alarms;
    logic closed;
    logic [7:0] relay;
    logic soft_pend, alarm_pend;
    logic [3:0] ctl_s1, ctl_s2, ctl_s3;
    logic [31:0] dig_s1, dig_s2, meas_s1, meas_s2;
    logic [31:0] prdata;
    logic pslverr;
  } state_t;

  state_t r, n;
  logic [67:0] mem [RD_DEPTH];
  logic [67:0] rd_word;
  logic [PTR_W-1:0] rd_phys;
  logic [15:0] present;
  logic key_e, ext_e, adv_e, tot_e, trig, init_cmd, tot_rd_rst;
  logic [4:0] nxt;
  logic [3:0] alarm_set;
  logic soft_set;
  trig_src_t src;

  function automatic logic [15:0] list_mask(input logic [31:0] lst,
                                            input logic [3:0] len);
    logic [15:0] m;
    m = 16'h0000;
    for (int i = 0; i < LIST_LEN; i++) begin
      if (4'(i) < len) begin
        m[lst[i*4 +: 4]] = 1'b1;
      end
    end
    return m;
  endfunction

  // lowest listed code at or above from; bit 4 set when none is left
  function automatic logic [4:0] next_code(input logic [15:0] m,
                                           input logic [4:0] from);
    logic [4:0] res;
    res = 5'h10;
    for (int i = 15; i >= 0; i--) begin
      if (m[i] && 5'(i) >= from) begin
        res = 5'(i);
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] dig_value(input logic [3:0] code,
                                            input logic [31:0] d);
    case (code)
      CODE_DIG16A: return {16'h0000, d[15:0]};
      CODE_DIG16B: return {16'h0000, d[31:16]};
      CODE_DIG32: return d;
      default: return {24'h00_0000, d[(code - CODE_DIG0)*8 +: 8]};
    endcase
  endfunction

  function automatic logic [PTR_W-1:0] ptr_add(input logic [PTR_W-1:0] a,
                                               input logic [PTR_W-1:0] b);
    logic [PTR_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, RD_FULL}) begin
      s = s - {1'b0, RD_FULL};
    end
    return s[PTR_W-1:0];
  endfunction

  always_comb begin
    n = r;
    n.closed = 1'b0;
    alarm_set = 4'h0;
    soft_set = 1'b0;
    tot_rd_rst = 1'b0;
    trig = 1'b0;
    nxt = 5'h00;
    n.stamp = r.stamp + 32'h0000_0001;
    n.ctl_s1 = {key_in, ext_trig_in, advance_in, tot_in}; // [RQ22]
    n.ctl_s2 = r.ctl_s1;
    n.ctl_s3 = r.ctl_s2;
    n.dig_s1 = dig_in;
    n.dig_s2 = r.dig_s1;
    n.meas_s1 = meas_data_in;
    n.meas_s2 = r.meas_s1;
    key_e = r.ctl_s2[3] & ~r.ctl_s3[3];
    ext_e = r.ctl_s2[2] & ~r.ctl_s3[2];
    adv_e = r.ctl_s2[1] & ~r.ctl_s3[1]; // [RQ22]
    tot_e = r.ctrl[CTRL_FALL] ? (~r.ctl_s2[0] & r.ctl_s3[0])
                              : (r.ctl_s2[0] & ~r.ctl_s3[0]); // [RQ17]
    n.tot = r.tot + {31'h0000_0000, tot_e}; // [RQ16] [RQ18]
    present = list_mask(r.list, r.len);
    src = trig_src_t'(r.ctrl[CTRL_SRC_LSB +: 3]);
    init_cmd = apb_in.psel & apb_in.penable & apb_in.pwrite &
               (apb_in.paddr == OFF_CMD) & apb_in.pwdata[CMD_INIT];
    if (r.st != ST_IDLE) begin
      n.tmr = r.tmr + 32'h0000_0001;
    end
    case (r.st)
      ST_ARMED: begin
        case (src)
          TRIG_TIMER: trig = r.tmr >= r.timer;
          TRIG_KEY: trig = key_e;
          TRIG_SOFT: trig = r.soft_pend;
          TRIG_EXT: trig = ext_e;
          TRIG_ALARM: trig = r.alarm_pend; // [RQ20]
          default: trig = 1'b0;
        endcase
        if (trig) begin // [RQ9]
          n.soft_pend = 1'b0;
          n.alarm_pend = 1'b0;
          n.tmr = 32'h0000_0000;
          n.pos = 5'h00;
          n.st = ST_SELECT;
        end
      end
      ST_SELECT: begin
        if (r.ctrl[CTRL_NONSEQ]) begin // [RQ4]
          nxt = (r.pos < {1'b0, r.len}) ?
                {1'b0, r.list[r.pos[2:0]*4 +: 4]} : 5'h10;
          n.pos = r.pos + 5'h01;
        end else begin
          nxt = next_code(present, r.pos); // [RQ3]
          n.pos = nxt + 5'h01;
        end
        if (nxt[4]) begin
          n.sweeps_done = r.sweeps_done + 8'h01;
          n.st = (r.ctrl[CTRL_SWEEP_LSB +: 8] != 8'h00 &&
                  n.sweeps_done == r.ctrl[CTRL_SWEEP_LSB +: 8]) ?
                 ST_IDLE : ST_ARMED;
        end else begin
          n.code = nxt[3:0]; // [RQ2]
          n.dly = 32'(SETTLE_CYC) + r.chdly; // [RQ10]
          n.relay = nxt[3] ? 8'h00 : 8'h01 << nxt[2:0]; // [RQ1]
          n.st = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (r.dly != 32'h0000_0000) begin
          n.dly = r.dly - 32'h0000_0001;
        end else if (!r.code[3]) begin
          n.closed = 1'b1; // [RQ11]
          n.st = ST_WAIT;
        end else begin
          if (r.code == CODE_TOT) begin // [RQ13]
            n.meas = r.tot;
            tot_rd_rst = r.ctrl[CTRL_RDRST];
          end else begin
            n.meas = dig_value(r.code, r.dig_s2); // [RQ14]
          end
          n.st = ST_STORE;
        end
      end
      ST_WAIT: begin
        if (adv_e) begin // [RQ12]
          n.meas = r.meas_s2;
          n.relay = 8'h00;
          n.st = ST_STORE;
        end
      end
      ST_STORE: begin
        n.wptr = (r.wptr == RD_LAST) ? '0 : r.wptr + 1'b1; // [RQ21]
        if (r.wptr == RD_LAST) begin
          n.wrapped = 1'b1; // [RQ6]
        end
        if (r.fill != RD_FULL) begin
          n.fill = r.fill + 1'b1; // [RQ5]
        end
        if (r.al_en[r.code] && r.meas > r.limit) begin // [RQ20]
          alarm_set[r.al_sel[r.code*2 +: 2]] = 1'b1;
          n.alarm_pend = 1'b1;
        end
        n.st = ST_SELECT;
      end
      default: n.st = r.st;
    endcase
    // bus: setup cycle registers read data, access cycle commits
    if (apb_in.psel && !apb_in.penable) begin
      n.pslverr = 1'b0;
      case (apb_in.paddr)
        OFF_CTRL: n.prdata = r.ctrl;
        OFF_LIST: n.prdata = r.list;
        OFF_LEN: n.prdata = {28'h000_0000, r.len};
        OFF_CHDLY: n.prdata = r.chdly;
        OFF_TIMER: n.prdata = r.timer;
        OFF_LIMIT: n.prdata = r.limit;
        OFF_AL_EN: n.prdata = {16'h0000, r.al_en};
        OFF_AL_SEL: n.prdata = r.al_sel;
        OFF_STAT: n.prdata = {20'h0_0000, r.alarms, 2'b00, r.code,
                              r.wrapped, r.st != ST_IDLE};
        OFF_FILL: n.prdata = 32'(r.fill);
        OFF_RD_IDX: n.prdata = 32'(r.rd_idx);
        OFF_RD_DATA: n.prdata = rd_word[31:0]; // [RQ7]
        OFF_RD_STAMP: n.prdata = rd_word[63:32];
        OFF_RD_CHAN: n.prdata = {28'h000_0000, rd_word[67:64]};
        OFF_DIG: n.prdata = r.dig_s2; // [RQ15]
        OFF_TOT: n.prdata = r.tot; // [RQ16]
        default: begin
          n.prdata = 32'h0000_0000;
          n.pslverr = apb_in.paddr != OFF_CMD;
        end
      endcase
    end
    if (apb_in.psel && apb_in.penable) begin
      if (!apb_in.pwrite && apb_in.paddr == OFF_TOT) begin
        tot_rd_rst = tot_rd_rst | r.ctrl[CTRL_RDRST];
      end
      if (apb_in.pwrite) begin
        case (apb_in.paddr)
          OFF_CTRL: n.ctrl = apb_in.pwdata;
          OFF_LIST: n.list = apb_in.pwdata;
          OFF_LEN: n.len = (apb_in.pwdata[3:0] > 4'h8) ? 4'h8
                                                       : apb_in.pwdata[3:0];
          OFF_CHDLY: n.chdly = apb_in.pwdata;
          OFF_TIMER: n.timer = apb_in.pwdata;
          OFF_LIMIT: n.limit = apb_in.pwdata;
          OFF_AL_EN: n.al_en = apb_in.pwdata[15:0];
          OFF_AL_SEL: n.al_sel = apb_in.pwdata;
          OFF_RD_IDX: n.rd_idx = apb_in.pwdata[PTR_W-1:0];
          OFF_CMD: begin
            soft_set = apb_in.pwdata[CMD_SOFT];
            if (apb_in.pwdata[CMD_ALCLR]) begin
              n.alarms = 4'h0;
            end
            if (apb_in.pwdata[CMD_ABORT]) begin
              n.st = ST_IDLE;
              n.relay = 8'h00;
            end else if (init_cmd) begin
              n.wptr = '0; // [RQ8]
              n.fill = '0;
              n.wrapped = 1'b0;
              n.sweeps_done = 8'h00;
              n.tmr = 32'h0000_0000;
              n.relay = 8'h00;
              n.alarm_pend = 1'b0;
              n.st = ST_ARMED;
            end
          end
          default: n.ctrl = r.ctrl;
        endcase
      end
    end
    if (tot_rd_rst) begin
      n.tot = {31'h0000_0000, tot_e}; // [RQ19]
    end
    n.alarms = n.alarms | alarm_set;
    n.soft_pend = n.soft_pend | soft_set;
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.ctrl <= CTRL_RST;
      r.timer <= TIMER_RST;
    end else begin
      r <= n;
    end
  end

  // oldest entry sits at the write pointer once the buffer has wrapped
  assign rd_phys = ptr_add(r.wrapped ? r.wptr : '0, r.rd_idx); // [RQ7]

  always_ff @(posedge clk_in) begin
    if (r.st == ST_STORE) begin
      mem[r.wptr] <= {r.code, r.stamp, r.meas}; // [RQ5] [RQ21]
    end
    rd_word <= mem[rd_phys];
  end

  assign apb_out.pready = 1'b1;
  assign apb_out.pslverr = r.pslverr;
  assign apb_out.prdata = r.prdata;
  assign relay_sel_out = r.relay;
  assign chan_closed_out = r.closed;
  assign alarm_out = r.alarms;
  assign scanning_out = r.st != ST_IDLE;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  a_relay_one_hot: assert property ($onehot0(r.relay)) // [RQ1]
    else $error("more than one relay closed");
  a_store_listed: assert property (r.st == ST_STORE |->
    present[r.code]) // [RQ2]
    else $error("stored reading of unlisted channel");
  a_seq_order: assert property ((r.st == ST_SELECT &&
    !r.ctrl[CTRL_NONSEQ]) ##1 r.st == ST_SETTLE |->
    r.pos == {1'b0, r.code} + 5'h01) // [RQ3]
    else $error("ascending order broken");
  a_nonseq_order: assert property ((r.st == ST_SELECT &&
    r.ctrl[CTRL_NONSEQ]) ##1 r.st == ST_SETTLE |->
    r.code == r.list[$past(r.pos[2:0])*4 +: 4]) // [RQ4]
    else $error("stored order broken");
  a_fill_bound: assert property (r.fill <= RD_FULL) // [RQ5]
    else $error("fill count beyond depth");
  a_ptr_wrap: assert property (r.st == ST_STORE && r.wptr == RD_LAST &&
    !init_cmd |=> r.wptr == '0 && r.wrapped) // [RQ6]
    else $error("write pointer failed to wrap");
  a_init_clear: assert property (init_cmd && !apb_in.pwdata[CMD_ABORT]
    |=> r.fill == '0 && r.wptr == '0 && r.st == ST_ARMED) // [RQ8]
    else $error("new scan kept old readings");
  a_closed_settle: assert property ($rose(r.closed) |->
    $past(r.st) == ST_SETTLE && $past(r.dly) == 32'h0000_0000 &&
    r.relay != 8'h00) // [RQ11]
    else $error("closed pulse before settling");
  a_closed_single: assert property (r.closed |=> !r.closed) // [RQ22]
    else $error("closed pulse longer than a cycle");
  a_tot_wrap: assert property (r.tot == 32'hFFFF_FFFF && tot_e &&
    !tot_rd_rst |=> r.tot == 32'h0000_0000) // [RQ18]
    else $error("totalizer did not roll over");
  a_tot_rdrst: assert property (tot_rd_rst && tot_e |=>
    r.tot == 32'h0000_0001) // [RQ19]
    else $error("edge lost on read-and-reset");
  a_idle_open: assert property (r.st == ST_IDLE |->
    r.relay == 8'h00) // [RQ2]
    else $error("relay closed while no scan runs");
  a_tot_count: assert property (!tot_rd_rst |=>
    r.tot == $past(r.tot) + 32'($past(tot_e))) // [RQ16] [RQ17]
    else $error("totalizer count step wrong");
  a_dig_step: assert property (r.st == ST_SETTLE &&
    r.dly == 32'h0000_0000 && r.code[3] && r.code != CODE_TOT |=>
    r.meas == dig_value($past(r.code), $past(r.dig_s2))) // [RQ13]
    else $error("digital step took wrong port value");
  a_alarm_start: assert property (r.st == ST_ARMED &&
    src == TRIG_ALARM && r.alarm_pend &&
    !(apb_in.psel && apb_in.penable && apb_in.pwrite &&
      apb_in.paddr == OFF_CMD) |=> r.st == ST_SELECT) // [RQ9] [RQ20]
    else $error("logged alarm did not start a sweep");

  c_sweep_done: cover property (r.st == ST_SELECT ##1 r.st == ST_ARMED);
  c_mem_wrap: cover property ($rose(r.wrapped));
  c_ext_step: cover property (r.st == ST_WAIT ##1 r.st == ST_STORE);
  c_alarm_set: cover property ($rose(r.alarms[0]));
  c_alarm_start: cover property (r.st == ST_ARMED &&
    src == TRIG_ALARM && r.alarm_pend);
endmodule // scan_sequencer_totalizer
`default_nettype wire
